// *** rtl/sfo_stream_flow_ordering.v ***
/*
 * Ingress ordering stage of a stream end point: requests arrive tagged
 * with a flow label, wait in one queue per flow and leave toward the
 * fabric in an order that keeps the delivery passing restrictions.
 * Assumes synchronous inputs, one clock, and a receiver that may stall.
 * Ordering is kept per flow label only, not per source and destination
 * pair; that is stricter than needed but never breaks a passing rule.
 * Ready drops while any queue is full, whatever label comes next, so a
 * burst on one flow can briefly hold back the others.
 */
`timescale 1ns/10ps
`include "sfo_defines.vh"

module sfo_stream_flow_ordering (
    input  wire                        ref_clk_in,
    input  wire                        rst_b_in,
    input  wire                        single_vc_in,
    input  wire                        in_valid_in,
    output wire                        in_ready_out,
    input  wire [`SFO_ID_W-1:0]        in_src_id_in,
    input  wire [`SFO_ID_W-1:0]        in_dst_id_in,
    input  wire [`SFO_CHAN_W-1:0]      in_chan_in,
    input  wire [`SFO_PRIO_W-1:0]      in_prio_in,
    input  wire [`SFO_COS_W-1:0]       in_cos_in,
    input  wire [`SFO_STREAM_W-1:0]    in_stream_in,
    input  wire [`SFO_DATA_W-1:0]      in_data_in,
    input  wire                        in_last_in,
    output wire                        eg_valid_out,
    input  wire                        eg_ready_in,
    output wire [`SFO_ID_W-1:0]        eg_src_id_out,
    output wire [`SFO_ID_W-1:0]        eg_dst_id_out,
    output wire [`SFO_CHAN_W-1:0]      eg_chan_out,
    output wire [`SFO_PRIO_W-1:0]      eg_prio_out,
    output wire [`SFO_TAG_W-1:0]       eg_vstag_out,
    output wire [`SFO_BIN_BITS-1:0]    eg_bin_out,
    output wire [`SFO_DATA_W-1:0]      eg_data_out,
    output wire                        eg_last_out
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions.

// Picks a queue: the round-robin channel is tried first, and inside a
// channel the highest priority queue that holds data wins. Bit 3 is valid.
function [3:0] sfo_pick;
    input [`SFO_QN-1:0] ne;
    input               rr;
    integer             k;
    integer             p;
    reg                 ch;
    begin
        sfo_pick = 4'h0;
        for (k = 1; k >= 0; k = k - 1) begin
            ch = rr ^ k[0];
            for (p = 0; p < 4; p = p + 1) begin
                if (ne[{ch, p[1:0]}]) begin
                    sfo_pick = {1'b1, ch, p[1:0]};
                end
            end
        end
    end
endfunction

// Ring pointer step. The depth is a power of two, so the wrap at the
// end of the ring comes free from the pointer width.
function [`SFO_PTR_W-1:0] sfo_ptr_inc;
    input [`SFO_PTR_W-1:0] ptr;
    begin
        sfo_ptr_inc = ptr + 2'h1;
    end
endfunction

// True when a queue index names the queue at loop position n.
function sfo_hit;
    input [`SFO_QIDX_W-1:0] q;
    input integer           n;
    begin
        sfo_hit = (q == n[`SFO_QIDX_W-1:0]);
    end
endfunction

// Occupancy after one cycle. A push and a grant on the same queue in
// one cycle cancel, so a queue at full throughput keeps an exact count.
function [`SFO_CNT_W-1:0] sfo_cnt_step;
    input [`SFO_CNT_W-1:0] cnt;
    input                  inc;
    input                  dec;
    begin
        sfo_cnt_step = cnt;
        if (inc && !dec) begin
            sfo_cnt_step = cnt + 3'h1;
        end
        if (dec && !inc) begin
            sfo_cnt_step = cnt - 3'h1;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State.

reg [`SFO_ENT_W-1:0]   mem [0:`SFO_QN*`SFO_DEPTH-1];
reg [`SFO_CNT_W-1:0]   cnt_reg [0:`SFO_QN-1];
reg [`SFO_PTR_W-1:0]   wp_reg  [0:`SFO_QN-1];
reg [`SFO_PTR_W-1:0]   rp_reg  [0:`SFO_QN-1];
reg                    in_ready_reg;
reg                    rr_reg;
reg                    eg_valid_reg;
reg [`SFO_REC_W-1:0]   eg_rec_reg;
reg                    skid_valid_reg;
reg [`SFO_REC_W-1:0]   skid_rec_reg;

reg [`SFO_QN-1:0]      nonempty;
reg [`SFO_CNT_W-1:0]   cnt_next [0:`SFO_QN-1];
reg                    in_ready_next;
integer                i_ne;
integer                i_cnt;
integer                i_rst;

wire                   push;
wire                   push_chan;
wire [`SFO_QIDX_W-1:0] push_q;
wire [`SFO_ENT_W-1:0]  push_ent;
wire [3:0]             pick;
wire                   buf_ready;
wire                   grant;
wire [`SFO_QIDX_W-1:0] gq;
wire [`SFO_REC_W-1:0]  grant_rec;
wire                   pop;
wire                   out_free;

////////////////////////////////////////////////////////////////////////////////
// Intake: the label chooses the queue.

assign push     = in_valid_in & in_ready_reg;
// In single channel mode the channel number is dropped, so all labels
// collapse onto channel 0 and order only by priority letter.
// A request is taken only on an edge where valid and ready both stand.
assign push_chan = in_chan_in & ~single_vc_in;
assign push_q   = {push_chan, in_prio_in};
// The label enters unchanged except in single channel mode, where its channel
// bit is cleared, so a stream that keeps one label stays in one queue.
assign push_ent = {in_last_in, in_src_id_in, in_dst_id_in,
                   in_cos_in, in_stream_in, in_data_in};

////////////////////////////////////////////////////////////////////////////////
// Selection toward the egress buffer.

// A queue takes part in arbitration only while its count is nonzero.
always @* begin
    for (i_ne = 0; i_ne < `SFO_QN; i_ne = i_ne + 1) begin
        nonempty[i_ne] = (cnt_reg[i_ne] != `SFO_CNT_RST);
    end
end

// Strict priority inside a channel: a lower queue is served only while
// every higher queue of its channel is empty, so nothing lower can pass
// an earlier higher request, while a later higher one may jump ahead.
assign pick      = sfo_pick(nonempty, rr_reg);
assign buf_ready = ~skid_valid_reg;
assign grant     = pick[3] & buf_ready;
assign gq        = pick[2:0];
assign grant_rec = {gq, mem[{gq, rp_reg[gq]}]};

always @* begin
    in_ready_next = 1'b1;
    for (i_cnt = 0; i_cnt < `SFO_QN; i_cnt = i_cnt + 1) begin
        cnt_next[i_cnt] = sfo_cnt_step(cnt_reg[i_cnt],
                                       push && sfo_hit(push_q, i_cnt),
                                       grant && sfo_hit(gq, i_cnt));
        // Ready is registered and the label of the next request is not
        // known ahead, so intake stops as soon as any queue is full;
        // the count therefore never passes the queue depth.
        if (cnt_next[i_cnt] == `SFO_DEPTH) begin
            in_ready_next = 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Queue storage: each flow is a first-in first-out ring.

// The storage has no reset: a word is read only while its queue count
// says it was written, so stale contents are never seen.
always @(posedge ref_clk_in) begin
    if (push) begin
        mem[{push_q, wp_reg[push_q]}] <= push_ent;
    end
end

always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        for (i_rst = 0; i_rst < `SFO_QN; i_rst = i_rst + 1) begin
            cnt_reg[i_rst] <= `SFO_CNT_RST;
            wp_reg[i_rst]  <= `SFO_PTR_RST;
            rp_reg[i_rst]  <= `SFO_PTR_RST;
        end
        in_ready_reg <= 1'b0;
        rr_reg       <= 1'b0;
    end else begin
        for (i_rst = 0; i_rst < `SFO_QN; i_rst = i_rst + 1) begin
            cnt_reg[i_rst] <= cnt_next[i_rst];
        end
        if (push) begin
            wp_reg[push_q] <= sfo_ptr_inc(wp_reg[push_q]);
        end
        if (grant) begin
            rp_reg[gq] <= sfo_ptr_inc(rp_reg[gq]);
            // Channels carry no mutual order, so the other channel gets
            // the next turn to keep one from starving the other.
            rr_reg     <= ~gq[2];
        end
        in_ready_reg <= in_ready_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Two-entry egress buffer: a stall by the receiver parks the granted
// record in the skid slot, and selection halts until the slot drains.
// Halting selection costs no output cycle after a stall, since the parked record
// covers the cycle in which selection resumes, and the buffer never needs more than these two entries.

assign pop      = eg_valid_reg & eg_ready_in;
assign out_free = ~eg_valid_reg | pop;

always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        eg_valid_reg   <= 1'b0;
        eg_rec_reg     <= `SFO_REC_RST;
        skid_valid_reg <= 1'b0;
        skid_rec_reg   <= `SFO_REC_RST;
    end else begin
        // One path in, one path out: records leave exactly in the order
        // they were granted, which sets the completion order downstream.
        if (skid_valid_reg) begin
            if (out_free) begin
                eg_rec_reg     <= skid_rec_reg;
                eg_valid_reg   <= 1'b1;
                skid_valid_reg <= 1'b0;
            end
        end else if (grant) begin
            if (out_free) begin
                eg_rec_reg   <= grant_rec;
                eg_valid_reg <= 1'b1;
            end else begin
                skid_rec_reg   <= grant_rec;
                skid_valid_reg <= 1'b1;
            end
        end else if (pop) begin
            eg_valid_reg <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs: all fields come from the egress record flip-flops. There is
// no answer path at all; a request is done once it leaves.

wire [`SFO_ID_W-1:0]     rec_src;
wire [`SFO_ID_W-1:0]     rec_dst;
wire [`SFO_COS_W-1:0]    rec_cos;
wire [`SFO_STREAM_W-1:0] rec_stream;

assign rec_src       = eg_rec_reg[`SFO_ENT_SRC];
assign rec_dst       = eg_rec_reg[`SFO_ENT_DST];
assign rec_cos       = eg_rec_reg[`SFO_ENT_COS];
assign rec_stream    = eg_rec_reg[`SFO_ENT_STREAM];

assign in_ready_out  = in_ready_reg;
assign eg_valid_out  = eg_valid_reg;
assign eg_src_id_out = rec_src;
assign eg_dst_id_out = rec_dst;
assign eg_chan_out   = eg_rec_reg[`SFO_REC_CHAN];
assign eg_prio_out   = eg_rec_reg[`SFO_REC_PRIO];
assign eg_data_out   = eg_rec_reg[`SFO_ENT_DATA];
assign eg_last_out   = eg_rec_reg[`SFO_ENT_LAST];
// The ingress side names the destination in the tag; an egress user
// would put the source there instead.
assign eg_vstag_out  = {rec_dst, rec_cos, rec_stream};
// Bin number from the most significant class bits downward; a device
// with more bins widens the slice from the top.
assign eg_bin_out    = rec_cos[`SFO_COS_W-1:`SFO_COS_W-`SFO_BIN_BITS];

endmodule // sfo_stream_flow_ordering

// *** rtl/sfo_defines.vh ***
/*
 * Constants of the flow ordering block: field widths, record layout,
 * queue geometry and reset values.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef SFO_DEFINES_VH
`define SFO_DEFINES_VH

// Identifier and field widths.
`define SFO_ID_W        8
`define SFO_COS_W       8
`define SFO_STREAM_W    16
`define SFO_DATA_W      32
`define SFO_CHAN_W      1
`define SFO_PRIO_W      2
`define SFO_BIN_BITS    2
`define SFO_TAG_W       32

// Queue geometry: one queue per flow label, channel above priority.
`define SFO_QN          8
`define SFO_QIDX_W      3
`define SFO_DEPTH       4
`define SFO_PTR_W       2
`define SFO_CNT_W       3
`define SFO_MEM_W       5

// Stored entry layout: last, src, dst, cos, stream, data.
`define SFO_ENT_W       73
`define SFO_ENT_DATA    31:0
`define SFO_ENT_STREAM  47:32
`define SFO_ENT_COS     55:48
`define SFO_ENT_DST     63:56
`define SFO_ENT_SRC     71:64
`define SFO_ENT_LAST    72

// Egress record: flow label above the stored entry.
`define SFO_REC_W       76
`define SFO_REC_PRIO    74:73
`define SFO_REC_CHAN    75

// Reset values.
`define SFO_CNT_RST     3'h0
`define SFO_PTR_RST     2'h0
`define SFO_REC_RST     76'h0

`endif

// *** testbench/sfo_sink.sv ***
/* Receiver model at the egress side of the flow ordering block.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/10ps
module sfo_sink (
    input  wire       ref_clk_in,
    input  wire       rst_b_in,
    input  wire [1:0] mode_in,
    output reg        ready_out
);
    // Mode 0 takes every record, 1 stalls at random, 2 refuses all.
    // Records are consumed in arrival order and nothing is sent back.
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            ready_out <= 1'h0;
        else
            ready_out <= mode_in == 2'h0 ||
                         (mode_in == 2'h1 && $urandom % 3 != 0);
    end
endmodule // sfo_sink

// *** testbench/sfo_chk.sv ***
/* Port checker of the flow ordering block.
   Assumes it is bound to the top module, one clock domain. */
`timescale 1ns/10ps
`include "sfo_defines.vh"
module sfo_chk (
    input wire                     ref_clk_in,
    input wire                     rst_b_in,
    input wire                     single_vc_in,
    input wire                     in_valid_in,
    input wire                     in_ready_out,
    input wire                     eg_valid_out,
    input wire                     eg_ready_in,
    input wire [`SFO_ID_W-1:0]     eg_dst_id_out,
    input wire [`SFO_CHAN_W-1:0]   eg_chan_out,
    input wire [`SFO_TAG_W-1:0]    eg_vstag_out,
    input wire [`SFO_BIN_BITS-1:0] eg_bin_out,
    input wire [`SFO_DATA_W-1:0]   eg_data_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_stall; eg_valid_out && !eg_ready_in; endsequence
    sequence s_take; in_valid_in && in_ready_out; endsequence
    // Quiet cycle then a take: nothing else is in flight.
    sequence s_idle_take;
        !(in_valid_in && in_ready_out) && !eg_valid_out ##1 s_take ##0 !eg_valid_out;
    endsequence
    property p_hold; s_stall |=> eg_valid_out; endproperty
    property p_stab; s_stall |=> $stable(eg_data_out) && $stable(eg_vstag_out); endproperty
    property p_tag; eg_valid_out |-> eg_vstag_out[31:24] == eg_dst_id_out; endproperty
    property p_bin; eg_valid_out |-> eg_bin_out == eg_vstag_out[23:22]; endproperty
    property p_one; single_vc_in && eg_valid_out |-> eg_chan_out == 1'h0; endproperty
    property p_lat; s_idle_take |-> ##[1:2] eg_valid_out; endproperty
    property p_up; $rose(rst_b_in) |=> in_ready_out; endproperty
    property p_fell; $fell(in_ready_out) |-> $past(in_valid_in && in_ready_out); endproperty
    a_hold: assert property (p_hold) else $error("record dropped on stall");
    a_stab: assert property (p_stab) else $error("record changed on stall");
    a_tag: assert property (p_tag) else $error("stream tag head wrong");
    a_bin: assert property (p_bin) else $error("bin not leading class bits");
    a_one: assert property (p_one) else $error("channel kept in single mode");
    a_lat: assert property (p_lat) else $error("idle request not forwarded");
    a_up: assert property (p_up) else $error("intake not ready after reset");
    a_fell: assert property (p_fell) else $error("ready fell without a take");
endmodule // sfo_chk

bind sfo_stream_flow_ordering sfo_chk u_sfo_chk (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .single_vc_in(single_vc_in),
    .in_valid_in(in_valid_in), .in_ready_out(in_ready_out), .eg_valid_out(eg_valid_out),
    .eg_ready_in(eg_ready_in), .eg_dst_id_out(eg_dst_id_out), .eg_chan_out(eg_chan_out),
    .eg_vstag_out(eg_vstag_out), .eg_bin_out(eg_bin_out), .eg_data_out(eg_data_out));

// *** testbench/tb_stream_flow_ordering.sv ***
/* Self-checking bench of the flow ordering block with a queue model.
   Assumes the receiver model and the bound checker are compiled. */
`timescale 1ns/10ps
module tb_stream_flow_ordering;
    reg          ref_clk_in = 0, rst_b_in = 0, single_vc_in = 0, in_valid_in = 0;
    reg          in_chan_in = 0, in_last_in = 0;
    reg  [1:0]   in_prio_in = 0, mode = 0;
    reg  [7:0]   in_src_id_in = 0, in_dst_id_in = 0, in_cos_in = 0;
    reg  [15:0]  in_stream_in = 0;
    reg  [31:0]  in_data_in = 0;
    wire         in_ready_out, eg_valid_out, eg_ready_in, eg_chan_out, eg_last_out;
    wire [1:0]   eg_prio_out, eg_bin_out;
    wire [7:0]   eg_src_id_out, eg_dst_id_out;
    wire [31:0]  eg_vstag_out, eg_data_out;
    int          err_total = 0, samples_checked = 0, seq = 0, cyc = 0, low_seen = 0;
    logic [75:0] q[8][$];
    int          sq[8][$];
    initial forever #25 ref_clk_in = ~ref_clk_in;
    sfo_stream_flow_ordering u_sfo_stream_flow_ordering (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .single_vc_in(single_vc_in),
        .in_valid_in(in_valid_in), .in_ready_out(in_ready_out), .in_src_id_in(in_src_id_in),
        .in_dst_id_in(in_dst_id_in), .in_chan_in(in_chan_in), .in_prio_in(in_prio_in),
        .in_cos_in(in_cos_in), .in_stream_in(in_stream_in), .in_data_in(in_data_in),
        .in_last_in(in_last_in), .eg_valid_out(eg_valid_out), .eg_ready_in(eg_ready_in),
        .eg_src_id_out(eg_src_id_out), .eg_dst_id_out(eg_dst_id_out), .eg_chan_out(eg_chan_out),
        .eg_prio_out(eg_prio_out), .eg_vstag_out(eg_vstag_out), .eg_bin_out(eg_bin_out),
        .eg_data_out(eg_data_out), .eg_last_out(eg_last_out));
    sfo_sink u_sfo_sink (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .mode_in(mode),
        .ready_out(eg_ready_in));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [75:0] e, input logic [75:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    function int left();
        left = 0;
        foreach (q[i]) left += q[i].size();
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    // Sampled at the falling edge so registered outputs have settled.
    always @(negedge ref_clk_in) begin : mon
        logic [2:0] k;
        int         v;
        if (!rst_b_in) begin
            foreach (q[i]) q[i].delete();
            foreach (sq[i]) sq[i].delete();
        end else begin
            if (!in_ready_out) low_seen = 1;
            if (eg_valid_out && eg_ready_in) begin
                k = {eg_chan_out, eg_prio_out};
                v = 0;
                if (q[k].size() == 0) chk("spurious", 76'h0, 76'h1);
                else begin
                    chk("record", q[k][0],
                        {k, eg_last_out, eg_src_id_out, eg_vstag_out, eg_data_out});
                    for (int p = k + 1; p <= {k[2], 2'h3}; p++)
                        if (sq[p].size() && sq[p][0] < sq[k][0]) v++;
                    chk("order", 76'h0, v);
                    void'(q[k].pop_front());
                    void'(sq[k].pop_front());
                end
            end
            if (in_valid_in && in_ready_out) begin
                k = {single_vc_in ? 1'h0 : in_chan_in, in_prio_in};
                q[k].push_back({k, in_last_in, in_src_id_in, in_dst_id_in, in_cos_in, in_stream_in,
                    in_data_in});
                sq[k].push_back(seq++);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // A request is held unchanged until the edge that takes it.
    task run(input int n, input logic [1:0] m, input logic sv);
        mode <= m;
        single_vc_in <= sv;
        repeat (n) begin
            @(posedge ref_clk_in);
            if (!in_valid_in || in_ready_out) begin
                in_valid_in <= $urandom % 2;
                {in_src_id_in, in_dst_id_in} <= 16'($urandom % 4);
                {in_chan_in, in_prio_in, in_last_in, in_cos_in} <= 12'($urandom);
                {in_stream_in, in_data_in} <= 48'({$urandom, $urandom});
            end
        end
        mode <= 2'h0;
        do @(posedge ref_clk_in); while (in_valid_in && !in_ready_out);
        in_valid_in <= 1'h0;
    endtask
    task drain(input string name);
        repeat (300) if (left() > 0) @(posedge ref_clk_in);
        chk("left", 76'h0, left());
        $display("test %s done", name);
    endtask
    initial begin
        void'($urandom(2));
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        run(300, 2'h0, 1'h0);
        drain("flow order");
        run(400, 2'h1, 1'h0);
        drain("receiver stall");
        low_seen = 0;
        run(100, 2'h2, 1'h0);
        chk("refused", 76'h1, low_seen);
        drain("queue full");
        run(300, 2'h1, 1'h1);
        drain("single channel");
        run(50, 2'h1, 1'h0);
        rst_b_in <= 1'h0;
        repeat (2) @(negedge ref_clk_in);
        chk("reset outputs", 76'h0,
            {eg_valid_out, in_ready_out, eg_data_out, eg_vstag_out});
        @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        run(200, 2'h1, 1'h0);
        drain("mid reset");
        final_report();
    end
endmodule // tb_stream_flow_ordering
